// File: inc/sll_pkg.sv
// Constants and types for the serial loader link front end
// Function
// - First interface used locks out the other until reset or new code runs.
// - All timing counts crystal clock cycles; no faster clock is assumed.
// - Both interfaces feed one byte path with identical format and protocol.
// - Async frames are 8 data bits, no parity, one stop bit.
// - Loader times sync pulses and sets its async divisor from them.
// - After successful detection loader sends one 0xCC byte at that rate.
// - Synchronous port uses SPI format, clock polarity one, phase one.
// - Host is master driving the clock; loader is slave, no clock detection.
// - Loader answers packets with 0xCC on success, 0x33 on failure.
// - While awaiting a response, zero bytes are skipped; first non-zero taken.
package sll_pkg;
  // Register offsets
  localparam logic [7:0] SLL_REG_CTRL = 8'h00;
  localparam logic [7:0] SLL_REG_STATUS = 8'h04;
  localparam logic [7:0] SLL_REG_DIV = 8'h08;
  // Control field positions
  localparam int SLL_CTRL_EXPECT = 0;
  localparam int SLL_CTRL_ACK = 1;
  localparam int SLL_CTRL_NAK = 2;
  localparam int SLL_CTRL_EXIT = 3;
  // Status field positions
  localparam int SLL_ST_UART = 0;
  localparam int SLL_ST_SPI = 1;
  localparam int SLL_ST_BAUD = 2;
  localparam int SLL_ST_EXPECT = 3;
  localparam int SLL_ST_EXIT = 4;
  localparam int SLL_ST_OVR = 5;
  localparam int SLL_ST_FERR = 6;
  // Byte codes
  localparam logic [7:0] SLL_BYTE_SYNC = 8'h55;
  localparam logic [7:0] SLL_BYTE_ACK = 8'hCC;
  localparam logic [7:0] SLL_BYTE_NAK = 8'h33;
  localparam logic [7:0] SLL_BYTE_ZERO = 8'h00;
  // Timing in crystal cycles
  localparam int SLL_CLK_HZ = 10000000;
  localparam int SLL_BAUD_RATIO = 32;
  localparam logic [15:0] SLL_MIN_IV = 16'(2 * SLL_BAUD_RATIO);
  localparam logic [15:0] SLL_MAX_CNT = 16'hFFFF;
  localparam logic [3:0] SLL_EDGES_MEAS = 4'h8;
  localparam int SLL_AVG_SHIFT = 4;
  localparam logic [15:0] SLL_DIV_RST = 16'h0020;
  // Synchroniser reset levels {mosi, cs_n, sclk, rx}
  localparam logic [3:0] SLL_SYNC_RST = 4'h7;
  localparam int SLL_FIFO_W = 8;
  localparam int SLL_FIFO_D = 32;
  typedef enum logic [1:0] {SLL_LK_NONE = 2'b00, SLL_LK_UART = 2'b01,
                            SLL_LK_SPI = 2'b10} sll_lock_t;
  typedef enum logic [1:0] {SLL_AB_IDLE = 2'b00, SLL_AB_MEAS = 2'b01,
                            SLL_AB_TAIL = 2'b11, SLL_AB_DONE = 2'b10} sll_ab_t;
  typedef enum logic [1:0] {SLL_UR_IDLE = 2'b00, SLL_UR_START = 2'b01,
                            SLL_UR_DATA = 2'b11, SLL_UR_STOP = 2'b10} sll_ur_t;
endpackage

// File: core/sll_fifo.sv
// Byte FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module sll_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty from the word count
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign push = in_valid && in_ready;
  assign pop = (cnt_r != '0) && (!out_valid || out_ready);

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= AW'(rp_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  // Output stage
  always_ff @(posedge clock) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_r[rp_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: core/sll_link.sv
// Serial loader link: async port with autobaud and SPI mode 3 slave
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sll_link import sll_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic uart_rx,
  output logic uart_tx,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] pv_r;
  logic rx_l, rx_fall, rx_rise, sclk_fall, sclk_rise, cs_fall, cs_l, mosi_l;
  sll_lock_t lock_r;
  logic exit_r, expect_r, baud_ok_r, ovr_r, ferr_r;
  logic uart_ok, spi_ok;
  sll_ab_t ab_r;
  logic [15:0] ab_cnt_r, ab_first_r, div_r;
  logic [19:0] ab_tot_r;
  logic [3:0] ab_edges_r;
  logic iv_ok;
  sll_ur_t ur_r;
  logic [15:0] ur_cnt_r;
  logic [2:0] ur_idx_r;
  logic [7:0] ur_sh_r;
  logic ur_done;
  logic [9:0] ut_sh_r;
  logic [3:0] ut_n_r;
  logic [15:0] ut_cnt_r;
  logic [2:0] sp_bit_r;
  logic [7:0] sp_rsh_r, sp_tsh_r;
  logic sp_done;
  logic cc_pend_r, resp_pend_r, hold_v_r;
  logic [7:0] resp_r, hold_r;
  logic nb_v, take;
  logic [7:0] nb_d;
  logic rx_p;
  logic [7:0] rx_b;
  logic pend_v_r;
  logic [7:0] pend_r;
  logic fifo_in_ready;
  logic wr_ctrl;

  // Two-stage synchronisers, then an edge history register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_r <= SLL_SYNC_RST;
      s2_r <= SLL_SYNC_RST;
      pv_r <= SLL_SYNC_RST;
    end else begin
      s1_r <= {spi_mosi, spi_cs_n, spi_sclk, uart_rx};
      s2_r <= s1_r;
      pv_r <= s2_r;
    end
  end
  assign rx_l = s2_r[0];
  assign rx_fall = pv_r[0] && !s2_r[0];
  assign rx_rise = !pv_r[0] && s2_r[0];
  assign sclk_fall = pv_r[1] && !s2_r[1];
  assign sclk_rise = !pv_r[1] && s2_r[1];
  assign cs_l = !s2_r[2];
  assign cs_fall = pv_r[2] && !s2_r[2];
  assign mosi_l = s2_r[3];

  // Interface lock: first port to show activity wins
  assign uart_ok = !exit_r && (lock_r != SLL_LK_SPI);
  assign spi_ok = !exit_r && (lock_r != SLL_LK_UART);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lock_r <= SLL_LK_NONE;
    end else begin
      case (lock_r)
        SLL_LK_NONE: begin
          if (!exit_r && cs_fall) begin
            lock_r <= SLL_LK_SPI;
          end else if (!exit_r && rx_fall) begin
            lock_r <= SLL_LK_UART;
          end
        end
        default: lock_r <= lock_r;
      endcase
    end
  end

  // Interval check against the first spacing, within a quarter
  always_comb begin
    iv_ok = 1'b0;
    if (ab_edges_r == 4'h1) begin
      iv_ok = (ab_cnt_r >= SLL_MIN_IV);
    end else if (ab_cnt_r >= ab_first_r) begin
      iv_ok = ((ab_cnt_r - ab_first_r) <= (ab_first_r >> 2));
    end else begin
      iv_ok = ((ab_first_r - ab_cnt_r) <= (ab_first_r >> 2));
    end
  end

  // Autobaud: time eight 2-bit spacings of the 0x55 0x55 train
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ab_r <= SLL_AB_IDLE;
      ab_cnt_r <= '0;
      ab_tot_r <= '0;
      ab_first_r <= '0;
      ab_edges_r <= '0;
      div_r <= SLL_DIV_RST;
      baud_ok_r <= 1'b0;
    end else begin
      ab_cnt_r <= 16'(ab_cnt_r + 1'b1);
      ab_tot_r <= 20'(ab_tot_r + 1'b1);
      case (ab_r)
        SLL_AB_IDLE: begin
          if (uart_ok && rx_fall) begin
            ab_r <= SLL_AB_MEAS;
            ab_cnt_r <= 16'h0001;
            ab_tot_r <= 20'h00001;
            ab_edges_r <= 4'h1;
          end
        end
        SLL_AB_MEAS: begin
          if (ab_cnt_r == SLL_MAX_CNT || !uart_ok) begin
            ab_r <= SLL_AB_IDLE;
          end else if (rx_fall) begin
            if (!iv_ok) begin
              ab_r <= SLL_AB_IDLE;
            end else begin
              if (ab_edges_r == 4'h1) begin
                ab_first_r <= ab_cnt_r;
              end
              ab_cnt_r <= 16'h0001;
              ab_edges_r <= 4'(ab_edges_r + 1'b1);
              if (ab_edges_r == SLL_EDGES_MEAS) begin
                div_r <= 16'(ab_tot_r >> SLL_AVG_SHIFT);
                ab_r <= SLL_AB_TAIL;
                ab_edges_r <= '0;
              end
            end
          end
        end
        SLL_AB_TAIL: begin
          // Last data fall, then the stop bit rise
          if (ab_cnt_r == SLL_MAX_CNT || !uart_ok) begin
            ab_r <= SLL_AB_IDLE;
          end else if (rx_fall) begin
            ab_edges_r <= 4'h1;
          end else if (rx_rise && ab_edges_r == 4'h1) begin
            ab_r <= SLL_AB_DONE;
            baud_ok_r <= 1'b1;
          end
        end
        SLL_AB_DONE: ab_r <= SLL_AB_DONE;
        default: ab_r <= SLL_AB_IDLE;
      endcase
    end
  end

  // Async receiver at the measured divisor
  assign ur_done = (ur_r == SLL_UR_STOP) && (ur_cnt_r == '0) && rx_l;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ur_r <= SLL_UR_IDLE;
      ur_cnt_r <= '0;
      ur_idx_r <= '0;
      ur_sh_r <= '0;
      ferr_r <= 1'b0;
    end else begin
      if (ur_cnt_r != '0) begin
        ur_cnt_r <= 16'(ur_cnt_r - 1'b1);
      end
      case (ur_r)
        SLL_UR_IDLE: begin
          if (baud_ok_r && uart_ok && rx_fall) begin
            ur_r <= SLL_UR_START;
            ur_cnt_r <= div_r >> 1;
          end
        end
        SLL_UR_START: begin
          if (ur_cnt_r == '0) begin
            ur_r <= rx_l ? SLL_UR_IDLE : SLL_UR_DATA;
            ur_cnt_r <= 16'(div_r - 1'b1);
            ur_idx_r <= '0;
          end
        end
        SLL_UR_DATA: begin
          if (ur_cnt_r == '0) begin
            ur_sh_r <= {rx_l, ur_sh_r[7:1]};
            ur_idx_r <= 3'(ur_idx_r + 1'b1);
            ur_cnt_r <= 16'(div_r - 1'b1);
            if (ur_idx_r == 3'h7) begin
              ur_r <= SLL_UR_STOP;
            end
          end
        end
        SLL_UR_STOP: begin
          if (ur_cnt_r == '0) begin
            ur_r <= SLL_UR_IDLE;
            ferr_r <= ferr_r || !rx_l;
          end
        end
        default: ur_r <= SLL_UR_IDLE;
      endcase
    end
  end

  // Next byte to send: sync answer, then packet answer, then user data
  always_comb begin
    nb_v = 1'b1;
    nb_d = SLL_BYTE_ZERO;
    if (cc_pend_r) begin
      nb_d = SLL_BYTE_ACK;
    end else if (resp_pend_r) begin
      nb_d = resp_r;
    end else if (hold_v_r) begin
      nb_d = hold_r;
    end else begin
      nb_v = 1'b0;
    end
  end
  assign take = (lock_r == SLL_LK_UART) ? (uart_ok && baud_ok_r && nb_v && ut_n_r == '0)
              : (spi_ok && cs_l && sclk_fall && sp_bit_r == '0 && nb_v);
  assign wr_ctrl = reg_wr && (reg_addr == SLL_REG_CTRL);

  // Transmit sources
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cc_pend_r <= 1'b0;
      resp_pend_r <= 1'b0;
      resp_r <= SLL_BYTE_ZERO;
      hold_v_r <= 1'b0;
      hold_r <= SLL_BYTE_ZERO;
      tx_ready <= 1'b0;
    end else begin
      if (uart_ok && ab_r == SLL_AB_TAIL && rx_rise && ab_edges_r == 4'h1) begin
        cc_pend_r <= 1'b1;
      end else if (take && cc_pend_r) begin
        cc_pend_r <= 1'b0;
      end
      if (wr_ctrl && (reg_wdata[SLL_CTRL_ACK] || reg_wdata[SLL_CTRL_NAK])) begin
        resp_pend_r <= 1'b1;
        resp_r <= reg_wdata[SLL_CTRL_ACK] ? SLL_BYTE_ACK : SLL_BYTE_NAK;
      end else if (take && !cc_pend_r) begin
        resp_pend_r <= 1'b0;
      end
      if (tx_valid && tx_ready) begin
        hold_v_r <= 1'b1;
        hold_r <= tx_data;
      end else if (take && !cc_pend_r && !resp_pend_r) begin
        hold_v_r <= 1'b0;
      end
      tx_ready <= !hold_v_r && !(tx_valid && tx_ready);
    end
  end

  // Async transmitter: start, eight bits LSB first, stop
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ut_sh_r <= '1;
      ut_n_r <= '0;
      ut_cnt_r <= '0;
      uart_tx <= 1'b1;
    end else if (take && lock_r == SLL_LK_UART) begin
      ut_sh_r <= {1'b1, nb_d, 1'b0};
      ut_n_r <= 4'hA;
      ut_cnt_r <= 16'(div_r - 1'b1);
      uart_tx <= 1'b0;
    end else if (ut_n_r != '0) begin
      if (ut_cnt_r == '0) begin
        ut_sh_r <= {1'b1, ut_sh_r[9:1]};
        ut_n_r <= 4'(ut_n_r - 1'b1);
        ut_cnt_r <= 16'(div_r - 1'b1);
        uart_tx <= (ut_n_r == 4'h1) ? 1'b1 : ut_sh_r[1];
      end else begin
        ut_cnt_r <= 16'(ut_cnt_r - 1'b1);
      end
    end
  end

  // SPI mode 3 slave: drive on falling edge, sample on rising edge
  assign sp_done = spi_ok && cs_l && sclk_rise && sp_bit_r == 3'h7;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sp_bit_r <= '0;
      sp_rsh_r <= '0;
      sp_tsh_r <= '0;
      spi_miso_o <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (!spi_ok || !cs_l) begin
      sp_bit_r <= '0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= 1'b1;
      if (sclk_fall) begin
        if (sp_bit_r == '0) begin
          spi_miso_o <= nb_d[7];
          sp_tsh_r <= {nb_d[6:0], 1'b0};
        end else begin
          spi_miso_o <= sp_tsh_r[7];
          sp_tsh_r <= {sp_tsh_r[6:0], 1'b0};
        end
      end
      if (sclk_rise) begin
        sp_rsh_r <= {sp_rsh_r[6:0], mosi_l};
        sp_bit_r <= 3'(sp_bit_r + 1'b1);
      end
    end
  end

  // Common receive path for either port
  assign rx_p = ur_done || sp_done;
  assign rx_b = ur_done ? ur_sh_r : {sp_rsh_r[6:0], mosi_l};

  // Zero skip, holding stage stalled by the FIFO
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pend_v_r <= 1'b0;
      pend_r <= '0;
      ovr_r <= 1'b0;
      expect_r <= 1'b0;
    end else begin
      if (pend_v_r && fifo_in_ready) begin
        pend_v_r <= 1'b0;
      end
      if (rx_p && !(expect_r && rx_b == SLL_BYTE_ZERO)) begin
        if (pend_v_r && !fifo_in_ready) begin
          ovr_r <= 1'b1;
        end else begin
          pend_v_r <= 1'b1;
          pend_r <= rx_b;
        end
      end
      if (wr_ctrl && reg_wdata[SLL_CTRL_EXPECT]) begin
        expect_r <= 1'b1;
      end else if (rx_p && rx_b != SLL_BYTE_ZERO) begin
        expect_r <= 1'b0;
      end
    end
  end

  sll_fifo #(.W(SLL_FIFO_W), .D(SLL_FIFO_D)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_data(pend_r),
    .in_valid(pend_v_r),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // Register writes: loader exit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      exit_r <= 1'b0;
    end else if (wr_ctrl && reg_wdata[SLL_CTRL_EXIT]) begin
      exit_r <= 1'b1;
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        SLL_REG_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[SLL_ST_UART] <= (lock_r == SLL_LK_UART);
          reg_rdata[SLL_ST_SPI] <= (lock_r == SLL_LK_SPI);
          reg_rdata[SLL_ST_BAUD] <= baud_ok_r;
          reg_rdata[SLL_ST_EXPECT] <= expect_r;
          reg_rdata[SLL_ST_EXIT] <= exit_r;
          reg_rdata[SLL_ST_OVR] <= ovr_r;
          reg_rdata[SLL_ST_FERR] <= ferr_r;
        end
        SLL_REG_DIV: reg_rdata <= {16'h0000, div_r};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// File: bench/sll_link_chk.sv
// Port assertions for the serial loader link
`timescale 1ns/1ps
`default_nettype none
module sll_link_chk import sll_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic uart_tx,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  logic uart_seen_r;
  logic spi_seen_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Async port has sent a start bit since reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      uart_seen_r <= 1'b0;
    end else if (!uart_tx) begin
      uart_seen_r <= 1'b1;
    end
  end
  // SPI port has driven its data line since reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      spi_seen_r <= 1'b0;
    end else if (spi_miso_oe) begin
      spi_seen_r <= 1'b1;
    end
  end
  // Register reads and a settled high half of the SPI clock
  sequence st_rd;
    reg_rd && reg_addr == SLL_REG_STATUS;
  endsequence
  sequence div_rd;
    reg_rd && reg_addr == SLL_REG_DIV;
  endsequence
  sequence clk_high;
    !spi_cs_n && spi_miso_oe && spi_sclk;
  endsequence
  lock_one_a: assert property (st_rd |=> reg_rdata[1:0] != 2'b11)
    else $error("both ports locked");
  uart_excl_a: assert property (uart_seen_r |-> !spi_miso_oe)
    else $error("SPI driven after async use");
  spi_excl_a: assert property (spi_seen_r |-> uart_tx)
    else $error("async line driven after SPI use");
  div_floor_a: assert property (div_rd |=> reg_rdata[31:16] == 16'h0 &&
    reg_rdata[15:0] >= 16'h0020) else $error("divisor below limit");
  baud_src_a: assert property (st_rd |=> !reg_rdata[SLL_ST_BAUD] || reg_rdata[SLL_ST_UART])
    else $error("baud flag without async lock");
  start_bit_a: assert property ($fell(uart_tx) |-> (!uart_tx)[*8])
    else $error("start bit too short");
  mode3_a: assert property (clk_high [*5] |-> $stable(spi_miso_o))
    else $error("data out moved while clock high");
  miso_idle_a: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
    else $error("data out driven while deselected");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte dropped while stalled");
endmodule
bind sll_link sll_link_chk sll_link_chk_i (.clock, .nrst, .reg_addr, .reg_rd, .reg_rdata,
  .uart_tx, .spi_sclk, .spi_cs_n, .spi_miso_o, .spi_miso_oe, .rx_data, .rx_valid, .rx_ready);
`default_nettype wire

// File: bench/sll_host.sv
// Host model: async sender and receiver, SPI mode 3 master
`timescale 1ns/1ps
`default_nettype none
module sll_host import sll_pkg::*; #(
  parameter int LINK_NS = 800
) (
  input wire logic clock,
  output logic uart_rx,
  input wire logic uart_tx,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  output logic [7:0] got,
  output logic got_stb
);
  localparam int BIT_NS = 5 * LINK_NS;
  logic [7:0] sh;
  logic [7:0] ush;
  // Released data line shows the inverse of its last value
  wire miso = spi_miso_oe ? spi_miso_o : ~spi_miso_o;
  // Idle lines: async high, SPI deselected with clock high
  initial begin
    uart_rx = 1'b1;
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // One 8N1 frame, low bit first
  task uart_send(input logic [7:0] b);
    @(negedge clock);
    uart_rx = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      uart_rx = b[i];
      #BIT_NS;
    end
    uart_rx = 1'b1;
    #BIT_NS;
  endtask
  // Pattern that starts baud detection
  task uart_sync();
    uart_send(SLL_BYTE_SYNC);
    uart_send(SLL_BYTE_SYNC);
  endtask
  // Frame whose stop bit stays low
  task uart_break();
    @(negedge clock);
    uart_rx = 1'b0;
    #(11 * BIT_NS);
    uart_rx = 1'b1;
    #BIT_NS;
  endtask
  // Frame: drive on falling clock, sample on rising, high bit first
  task spi_xfer(input logic [7:0] b);
    @(negedge clock);
    spi_cs_n = 1'b0;
    #LINK_NS;
    for (int i = 7; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = b[i];
      #LINK_NS;
      spi_sclk = 1'b1;
      sh = {sh[6:0], miso};
      #LINK_NS;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    got = sh;
    got_stb = 1'b1;
    #LINK_NS;
    got_stb = 1'b0;
  endtask
  // Receive bytes on the async line, drop bad stop bits
  always @(negedge uart_tx) begin
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #BIT_NS;
      ush[i] = uart_tx;
    end
    #BIT_NS;
    if (uart_tx) begin
      got = ush;
      got_stb = 1'b1;
      #LINK_NS;
      got_stb = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_sll_link.sv
// Self-checking bench for the serial loader link
`timescale 1ns/1ps
`default_nettype none
module tb_sll_link import sll_pkg::*; ;
  logic clock, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_ready = 1'b0, tx_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, tx_data = 8'h00, rx_data, got, b;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic uart_rx, uart_tx, spi_sclk, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe;
  logic rx_valid, tx_ready, got_stb, stall = 1'b0, drain = 1'b0, rd_q = 1'b0;
  logic [7:0] rq[$], hq[$];
  logic [63:0] xq[$];
  logic [63:0] x;
  int n_errors = 0, checks = 0, seed = 88663, cyc = 0;
  sll_link sll_link_i (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .uart_rx, .uart_tx, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso_o, .spi_miso_oe,
    .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready);
  sll_host #(.LINK_NS(800)) sll_host_i (.clock, .uart_rx, .uart_tx, .spi_sclk, .spi_cs_n,
    .spi_mosi, .spi_miso_o, .spi_miso_oe, .got, .got_stb);
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Random consumer stalls and run limit
  always @(posedge clock) begin
    rx_ready <= stall ? 1'b0 : 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  // Register and byte results against the oldest note
  always @(posedge clock) begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1) begin
      x = xq.pop_front();
      chk(reg_rdata & x[63:32], x[31:0]);
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && !drain) begin
      chk({24'h0, rx_data}, rq.size() != 0 ? {24'h0, rq.pop_front()} : 32'hFFFF_FFFF);
    end
  end
  // Bytes seen by the host
  always @(posedge got_stb) begin
    if (hq.size() != 0) begin
      chk({24'h0, got}, {24'h0, hq.pop_front()});
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wrap_up();
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task do_reset();
    @(posedge clock);
    nrst <= 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    @(posedge clock);
    xq.push_back({m, v});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task send_tx(input logic [7:0] d);
    hq.push_back(d);
    @(posedge clock);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(posedge clock); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task sx(input logic [7:0] d);
    rq.push_back(d);
    sll_host_i.spi_xfer(d);
  endtask
  task wait_host();
    for (int k = 0; k < 3000 && hq.size() != 0; k++) begin
      @(posedge clock);
    end
  endtask
  // Main sequence
  initial begin
    do_reset();
    rd(SLL_REG_STATUS, '1, 32'h0);
    rd(SLL_REG_DIV, '1, 32'h20);
    rd(8'h0C, '1, 32'h0);
    hq.push_back(8'h00);
    sx(8'hA5);
    sll_host_i.uart_sync();
    wr(SLL_REG_DIV, 32'h1234);
    rd(SLL_REG_STATUS, '1, 32'h2);
    rd(SLL_REG_DIV, '1, 32'h20);
    for (int k = 1; k < 4; k++) begin
      wr(SLL_REG_CTRL, 32'(2 * k));
      hq.push_back(k == 2 ? SLL_BYTE_NAK : SLL_BYTE_ACK);
      sx(8'($random(seed)));
    end
    for (int k = 0; k < 3; k++) begin
      send_tx(8'($random(seed)));
      sx(8'($random(seed)));
    end
    wr(SLL_REG_CTRL, 32'h1);
    rd(SLL_REG_STATUS, 32'h8, 32'h8);
    for (int k = 0; k < 3; k++) begin
      sll_host_i.spi_xfer(8'h00);
    end
    sx(8'h3C);
    rd(SLL_REG_STATUS, 32'h8, 32'h0);
    repeat (20) @(posedge clock);
    stall = 1'b1;
    for (int k = 0; k < 40; k++) begin
      sll_host_i.spi_xfer(8'(k + 1));
    end
    rd(SLL_REG_STATUS, 32'h20, 32'h20);
    drain = 1'b1;
    stall = 1'b0;
    repeat (300) @(posedge clock);
    @(negedge clock);
    chk({31'h0, rx_valid}, 32'h0);
    drain = 1'b0;
    do_reset();
    rd(SLL_REG_STATUS, '1, 32'h0);
    hq.push_back(SLL_BYTE_ACK);
    sll_host_i.uart_sync();
    wait_host();
    rd(SLL_REG_STATUS, 32'h1F, 32'h5);
    rd(SLL_REG_DIV, '1, 32'h28);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      rq.push_back(b);
      send_tx(8'($random(seed)));
      sll_host_i.uart_send(b);
    end
    wait_host();
    sll_host_i.uart_break();
    rd(SLL_REG_STATUS, 32'h40, 32'h40);
    sll_host_i.spi_xfer(8'h96);
    wr(SLL_REG_CTRL, 32'h8);
    rd(SLL_REG_STATUS, 32'h10, 32'h10);
    sll_host_i.uart_send(8'h81);
    repeat (50) @(posedge clock);
    chk(32'(rq.size() + hq.size() + xq.size()), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
